// ===== src/psr_pkg.sv
/*
 * psr_pkg: constants and carrier types for the potentiometer status block.
 * assumes: used by psr_top and its bench, always as psr_pkg::name.
 */
package psr_pkg;

    // serial frame: 4 address bits, 2 command bits, 10 data bits, msb first
    localparam int unsigned FRAME_BITS = 16;
    localparam int unsigned HDR_BITS   = 6;
    localparam int unsigned DATA_BITS  = 10;
    localparam logic [1:0]  CMD_WRITE  = 2'h0;
    localparam logic [1:0]  CMD_READ   = 2'h3;

    // serial memory map
    localparam logic [3:0] ADDR_VOL_WIPER0 = 4'h0;
    localparam logic [3:0] ADDR_VOL_WIPER1 = 4'h1;
    localparam logic [3:0] ADDR_NV_WIPER0  = 4'h2;
    localparam logic [3:0] ADDR_NV_WIPER1  = 4'h3;
    localparam logic [3:0] ADDR_TERMINAL_CONNECT_REGISTER       = 4'h4;
    localparam logic [3:0] ADDR_STATUS     = 4'h5;

    localparam logic [3:0] RESERVED_ONES   = 4'hf;
    localparam logic [7:0] TERMINAL_CONNECT_REGISTER_ALL_WR     = 8'hff;
    localparam logic [7:0] TERMINAL_CONNECT_REGISTER_NET1_BITS  = 8'hf0;
    localparam logic [7:0] TERMINAL_CONNECT_REGISTER_NET0_BITS  = 8'h0f;
    localparam logic [1:0] SYNC_STAGES     = 2'h2;

    // bit 8..0 of the status register
    typedef struct packed {
        logic [3:0] reserved_high_bits;
        logic       eeprom_write_active_flag;
        logic       lock_flag_network1;
        logic       lock_flag_network0;
        logic       shutdown_pin_flag;
        logic       write_protect_flag;
    } psr_status_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [8:0] data;
    } psr_wr_t;

endpackage : psr_pkg

// ===== src/psr_sync.sv
/*
 * psr_sync: two flip-flop synchroniser for a bus of independent levels.
 * assumes: each bit is a slow level; no bits are related to one another.
 */
`timescale 1ns/100ps
`default_nettype none
module psr_sync #(
    parameter int unsigned W     = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input  wire logic         ref_clk,
    input  wire logic         resetn,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_q;

    // meta_q feeds sync_out only
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            meta_q   <= INIT;
            sync_out <= INIT;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule : psr_sync
`default_nettype wire

// ===== src/psr_top.sv
/*
 * psr_top: status register, write gating and shutdown handling of a
 * dual digital potentiometer, with its serial command port.
 * assumes: sck, cs_n, sdi, shutdown_pin_flag_n, wp_n are pins from outside the clock
 * domain; eeprom_busy, nv_* and hv_* come from logic on ref_clk; sck is
 * at most ref_clk/8 so every level lasts several clock cycles.
 */
`timescale 1ns/100ps
`default_nettype none
module psr_top (
    input  wire logic                ref_clk,
    input  wire logic                resetn,
    input  wire logic                cs_n,
    input  wire logic                sck,
    input  wire logic                sdi,
    output logic                     sdo,
    output logic                     sdo_oe,
    input  wire logic                shutdown_pin_flag_n,
    input  wire logic                wp_n,
    input  wire logic                eeprom_busy,
    input  wire logic                nv_lock1,
    input  wire logic                nv_lock0,
    input  wire logic                nv_wp,
    input  wire logic                hv_lock_valid,
    input  wire logic                hv_lock_net,
    input  wire logic                hv_lock_value,
    output psr_pkg::psr_status_t     status_q,
    output logic                     wr_pulse_q,
    output psr_pkg::psr_wr_t         wr_q,
    output logic [7:0]               terminal_connect_register_wr_mask_q,
    output logic                     cmd_refused_q,
    output logic                     term_a_off_q,
    output logic                     wiper_to_b_q
);
    logic [4:0]  pins_s;
    logic        cs_n_s, sck_s, sdi_s, shutdown_pin_flag_n_s, wp_n_s;
    logic        sck_prev_q;
    logic        rise, fall, active;
    logic [4:0]  bit_cnt_q;
    logic [14:0] rx_q;
    logic [15:0] word;
    logic [9:0]  tx_q;
    logic        reading_q;
    logic        lock1_q, lock0_q, load_pend_q;
    logic        vol_addr, nv_ok;

    // reset values are the idle pin levels, so no false sck edge follows
    psr_sync #(.W(5), .INIT(5'h13)) u_sync (
        .ref_clk  (ref_clk),
        .resetn   (resetn),
        .async_in ({cs_n, sck, sdi, shutdown_pin_flag_n, wp_n}),
        .sync_out (pins_s)
    );
    assign {cs_n_s, sck_s, sdi_s, shutdown_pin_flag_n_s, wp_n_s} = pins_s;

    // shutdown does not gate any of the serial logic below
    assign active = !cs_n_s;
    assign rise   = active && sck_s && !sck_prev_q;
    assign fall   = active && !sck_s && sck_prev_q;
    assign word   = {rx_q, sdi_s};

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            sck_prev_q <= 1'b0;
        end else begin
            sck_prev_q <= sck_s;
        end
    end

    // frame shifter; a frame cut short by cs_n rising is dropped
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            bit_cnt_q <= 5'h0;
            rx_q      <= 15'h0;
        end else if (!active) begin
            bit_cnt_q <= 5'h0;
        end else if (rise) begin
            rx_q <= word[14:0];
            if (bit_cnt_q == 5'(psr_pkg::FRAME_BITS - 1)) begin
                bit_cnt_q <= 5'h0;
            end else begin
                bit_cnt_q <= bit_cnt_q + 5'h1;
            end
        end
    end

    // read path: data bits follow the header, changed on falling sck
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            tx_q      <= 10'h0;
            reading_q <= 1'b0;
            sdo       <= 1'b0;
            sdo_oe    <= 1'b0;
        end else if (!active) begin
            reading_q <= 1'b0;
            sdo_oe    <= 1'b0;
        end else begin
            if (rise && bit_cnt_q == 5'(psr_pkg::HDR_BITS - 1)
                && word[1:0] == psr_pkg::CMD_READ) begin
                reading_q <= 1'b1;
                // other addresses are answered here with all zeros
                tx_q <= (word[5:2] == psr_pkg::ADDR_STATUS)
                        ? {1'b0, status_q} : 10'h0;
            end else if (rise
                && bit_cnt_q == 5'(psr_pkg::FRAME_BITS - 1)) begin
                reading_q <= 1'b0;
            end
            if (fall && reading_q) begin
                sdo    <= tx_q[psr_pkg::DATA_BITS-1];
                sdo_oe <= 1'b1;
                tx_q   <= {tx_q[8:0], 1'b0};
            end
        end
    end

    assign vol_addr = word[15:12] == psr_pkg::ADDR_VOL_WIPER0
                   || word[15:12] == psr_pkg::ADDR_VOL_WIPER1
                   || word[15:12] == psr_pkg::ADDR_TERMINAL_CONNECT_REGISTER
                   || word[15:12] == psr_pkg::ADDR_STATUS;
    assign nv_ok = !status_q.eeprom_write_active_flag || vol_addr;

    // write gating at the last bit of a write frame
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            wr_pulse_q     <= 1'b0;
            wr_q           <= '0;
            terminal_connect_register_wr_mask_q <= psr_pkg::TERMINAL_CONNECT_REGISTER_ALL_WR;
            cmd_refused_q  <= 1'b0;
        end else begin
            wr_pulse_q    <= 1'b0;
            cmd_refused_q <= 1'b0;
            if (rise && bit_cnt_q == 5'(psr_pkg::FRAME_BITS - 1)
                && word[11:10] == psr_pkg::CMD_WRITE) begin
                wr_q.addr <= word[15:12];
                wr_q.data <= word[8:0];
                terminal_connect_register_wr_mask_q <=
                    ~(({8{lock1_q}} & psr_pkg::TERMINAL_CONNECT_REGISTER_NET1_BITS)
                    | ({8{lock0_q}} & psr_pkg::TERMINAL_CONNECT_REGISTER_NET0_BITS));
                if (!nv_ok) begin
                    cmd_refused_q <= 1'b1;
                end else if (word[15:12] == psr_pkg::ADDR_STATUS) begin
                    wr_pulse_q <= 1'b0;
                end else if (lock1_q
                    && (word[15:12] == psr_pkg::ADDR_VOL_WIPER1
                     || word[15:12] == psr_pkg::ADDR_NV_WIPER1)) begin
                    cmd_refused_q <= 1'b1;
                end else if (lock0_q
                    && (word[15:12] == psr_pkg::ADDR_VOL_WIPER0
                     || word[15:12] == psr_pkg::ADDR_NV_WIPER0)) begin
                    cmd_refused_q <= 1'b1;
                end else begin
                    wr_pulse_q <= 1'b1;
                end
            end
        end
    end

    // locks: caught from nonvolatile bits after reset release, then
    // moved only by the high-voltage command decoder
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            load_pend_q <= 1'b1;
            lock1_q     <= 1'b0;
            lock0_q     <= 1'b0;
        end else if (load_pend_q) begin
            load_pend_q <= 1'b0;
            lock1_q     <= nv_lock1;
            lock0_q     <= nv_lock0;
        end else if (hv_lock_valid) begin
            if (hv_lock_net) begin
                lock1_q <= hv_lock_value;
            end else begin
                lock0_q <= hv_lock_value;
            end
        end
    end

    // status mirrors the shutdown and wp pins, eeprom_busy, nv_wp and the locks; nothing serial writes it
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            status_q     <= '0;
            term_a_off_q <= 1'b0;
            wiper_to_b_q <= 1'b0;
        end else begin
            status_q.reserved_high_bits <= psr_pkg::RESERVED_ONES;
            status_q.eeprom_write_active_flag <= eeprom_busy;
            status_q.lock_flag_network1       <= lock1_q;
            status_q.lock_flag_network0       <= lock0_q;
            status_q.shutdown_pin_flag        <= !shutdown_pin_flag_n_s;
            status_q.write_protect_flag <= !wp_n_s || nv_wp;
            term_a_off_q <= !shutdown_pin_flag_n_s;
            wiper_to_b_q <= !shutdown_pin_flag_n_s;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    sequence s_nv_write;
        wr_pulse_q && !(wr_q.addr == psr_pkg::ADDR_VOL_WIPER0
            || wr_q.addr == psr_pkg::ADDR_VOL_WIPER1
            || wr_q.addr == psr_pkg::ADDR_TERMINAL_CONNECT_REGISTER);
    endsequence

    a_eeprom_write_active_flag_follows: assert property (
        eeprom_busy |=> status_q.eeprom_write_active_flag)
        else $error("write-active flag not set while busy");
    a_busy_nv_block: assert property (
        s_nv_write |-> !$past(status_q.eeprom_write_active_flag))
        else $error("write accepted during eeprom cycle");
    a_lock1_wiper: assert property (
        wr_pulse_q && (wr_q.addr == psr_pkg::ADDR_VOL_WIPER1
            || wr_q.addr == psr_pkg::ADDR_NV_WIPER1)
        |-> !$past(lock1_q))
        else $error("locked wiper 1 written");
    a_lock0_wiper: assert property (
        wr_pulse_q && (wr_q.addr == psr_pkg::ADDR_VOL_WIPER0
            || wr_q.addr == psr_pkg::ADDR_NV_WIPER0)
        |-> !$past(lock0_q))
        else $error("locked wiper 0 written");
    // only a write frame refreshes the mask; reads leave it alone
    a_lock_mask: assert property (
        lock1_q && lock0_q && rise
            && bit_cnt_q == 5'(psr_pkg::FRAME_BITS - 1)
            && word[11:10] == psr_pkg::CMD_WRITE
        |=> terminal_connect_register_wr_mask_q == 8'h00)
        else $error("terminal_connect_register bits writable while locked");
    a_lock_stable: assert property (
        !hv_lock_valid && !load_pend_q |=> $stable(lock1_q)
            && $stable(lock0_q))
        else $error("lock changed without hv command");
    a_lock_load: assert property (
        load_pend_q |=> lock1_q == $past(nv_lock1))
        else $error("lock 1 not loaded from nonvolatile bit");
    a_shutdown_pin_flag_flag: assert property (
        !shutdown_pin_flag_n_s |=> status_q.shutdown_pin_flag ##1
            status_q.shutdown_pin_flag == !$past(shutdown_pin_flag_n_s))
        else $error("shutdown flag wrong");
    a_shutdown_pin_flag_term: assert property (
        status_q.shutdown_pin_flag |-> term_a_off_q && wiper_to_b_q)
        else $error("terminals not forced in shutdown");
    a_wp_or: assert property (
        ##1 status_q.write_protect_flag
            == ($past(!wp_n_s) || $past(nv_wp)))
        else $error("write-protect flag not the or of its sources");
    a_reserved_ones: assert property (
        $past(resetn) |-> status_q.reserved_high_bits
            == psr_pkg::RESERVED_ONES)
        else $error("reserved status bits not one");
    // after six rises the address sits in rx_q[5:2], the command below it
    a_status_read: assert property (
        reading_q && fall && bit_cnt_q == 5'(psr_pkg::HDR_BITS)
            && rx_q[5:2] == psr_pkg::ADDR_STATUS
        |=> sdo == 1'b0 && sdo_oe)
        else $error("status read did not start with bit 9 low");

endmodule : psr_top
`default_nettype wire

// ===== dv/psr_host.sv
/*
 * psr_host: behavioural serial controller that sends one frame per start.
 * assumes: driven from ref_clk; sck half period is 5 ref_clk cycles.
 */
`timescale 1ns/100ps
`default_nettype none
module psr_host (
    input  wire logic        ref_clk,
    input  wire logic        start,
    input  wire logic [15:0] frame,
    input  wire logic [4:0]  nbits,
    input  wire logic        sdo,
    input  wire logic        sdo_oe,
    output logic             cs_n,
    output logic             sck,
    output logic             sdi,
    output logic             done,
    output logic [15:0]      rx
);
    // one process drives every output; fewer than 16 bits aborts the
    // frame by raising cs_n early
    initial begin
        cs_n = 1'h1;
        sck  = 1'h0;
        sdi  = 1'h0;
        done = 1'h0;
        rx   = 16'h0;
        forever begin
            @(posedge ref_clk);
            done <= 1'h0;
            if (start) begin
                cs_n <= 1'h0;
                for (int i = 0; i < nbits; i++) begin
                    sdi <= frame[15-i];
                    repeat (5) @(posedge ref_clk);
                    sck <= 1'h1;
                    // a released sdo line is seen as an ever-changing level
                    rx <= {rx[14:0], sdo_oe ? sdo : ~rx[0]};
                    repeat (5) @(posedge ref_clk);
                    sck <= 1'h0;
                end
                repeat (5) @(posedge ref_clk);
                cs_n <= 1'h1;
                sdi  <= ~sdi;
                done <= 1'h1;
            end
        end
    end
endmodule : psr_host
`default_nettype wire

// ===== dv/psr_top_tb.sv
/*
 * psr_top_tb: self-checking bench for the potentiometer status block.
 * assumes: psr_host plays the serial controller at an 80 ns sck period.
 */
`timescale 1ns/100ps
`default_nettype none
module psr_top_tb;
    logic ref_clk = 0, resetn = 0, shutdown_pin_flag_n = 1, wp_n = 1, eeprom_busy = 0;
    logic nv_lock1 = 1, nv_lock0 = 0, nv_wp = 0, l1 = 1, l0 = 0;
    logic hv_lock_valid = 0, hv_lock_net = 0, hv_lock_value = 0;
    logic cs_n, sck, sdi, sdo, sdo_oe, wr_pulse_q, cmd_refused_q, h_done;
    logic term_a_off_q, wiper_to_b_q, h_start = 0;
    logic [7:0]  terminal_connect_register_wr_mask_q;
    logic [15:0] h_frame = 0, h_rx;
    logic [4:0]  h_nbits = 16;
    logic [31:0] seed = 32'h2019;
    logic [15:0] expq[$];
    psr_pkg::psr_status_t status_q;
    psr_pkg::psr_wr_t     wr_q;
    int failures = 0, cmp_count = 0, cycles = 0;

    psr_top psr_top_inst (.ref_clk(ref_clk), .resetn(resetn), .cs_n(cs_n),
        .sck(sck), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .shutdown_pin_flag_n(shutdown_pin_flag_n),
        .wp_n(wp_n), .eeprom_busy(eeprom_busy), .nv_lock1(nv_lock1),
        .nv_lock0(nv_lock0), .nv_wp(nv_wp), .hv_lock_valid(hv_lock_valid),
        .hv_lock_net(hv_lock_net), .hv_lock_value(hv_lock_value),
        .status_q(status_q), .wr_pulse_q(wr_pulse_q), .wr_q(wr_q),
        .terminal_connect_register_wr_mask_q(terminal_connect_register_wr_mask_q), .cmd_refused_q(cmd_refused_q),
        .term_a_off_q(term_a_off_q), .wiper_to_b_q(wiper_to_b_q));
    psr_host psr_host_inst (.ref_clk(ref_clk), .start(h_start),
        .frame(h_frame), .nbits(h_nbits), .sdo(sdo), .sdo_oe(sdo_oe),
        .cs_n(cs_n), .sck(sck), .sdi(sdi), .done(h_done), .rx(h_rx));

    initial begin
        forever #4 ref_clk = ~ref_clk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic logic [8:0] st();
        return {4'hf, eeprom_busy, l1, l0, ~shutdown_pin_flag_n, ~wp_n | nv_wp};
    endfunction : st

    task automatic summarize();
        $display("compares %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : summarize
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // an unexpected result meets an empty queue and fails on purpose
    task automatic got(input logic [15:0] v);
        if (expq.size() == 0)
            chk(v, 16'hffff);
        else
            chk(v, expq.pop_front());
    endtask : got
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : tick
    task automatic xfer(input logic [15:0] f, input logic [4:0] n);
        h_frame <= f;
        h_nbits <= n;
        h_start <= 1'h1;
        tick(1);
        h_start <= 1'h0;
        while (h_done !== 1'h1)
            tick(1);
        tick(6);
    endtask : xfer
    // k: 0 no answer, 1 accepted, 2 refused
    task automatic wr(input logic [3:0] a, input logic [1:0] k);
        seed = lfsr(seed);
        if (k == 2'h1)
            expq.push_back({3'h1, a, seed[8:0]});
        if (k == 2'h2)
            expq.push_back(16'h4000);
        xfer({a, 3'h0, seed[8:0]}, 5'h10);
    endtask : wr
    task automatic rd();
        expq.push_back({6'h20, 1'h0, st()});
        xfer({4'h5, 2'h3, 10'h0}, 5'h10);
    endtask : rd
    task automatic hv(input logic net, input logic val);
        hv_lock_valid <= 1'h1;
        hv_lock_net <= net;
        hv_lock_value <= val;
        tick(1);
        hv_lock_valid <= 1'h0;
        tick(3);
        if (net)
            l1 = val;
        else
            l0 = val;
    endtask : hv

    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (wr_pulse_q === 1'h1) got({3'h1, wr_q});
        if (cmd_refused_q === 1'h1) got(16'h4000);
        if (h_done === 1'h1 && h_frame[11:10] == 2'h3)
            got({6'h20, h_rx[9:0]});
        if (cycles == 20000) begin
            failures++;
            summarize();
        end
    end

    initial begin
        tick(5);
        resetn <= 1'h1;
        tick(6);
        chk(16'(status_q), 16'(st()));
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            {shutdown_pin_flag_n, wp_n, nv_wp, eeprom_busy} <= seed[3:0];
            tick(5);
            chk(16'(status_q), 16'(st()));
            chk({term_a_off_q, wiper_to_b_q}, {2{~shutdown_pin_flag_n}});
        end
        {shutdown_pin_flag_n, wp_n, nv_wp, eeprom_busy} <= 4'hc;
        tick(5);
        $display("test flags done");
        for (int m = 3; m >= 0; m--) begin
            hv(1'h1, m[1]);
            hv(1'h0, m[0]);
            chk(16'(status_q), 16'(st()));
            for (int a = 0; a < 4; a++)
                wr(a[3:0], (a[0] ? l1 : l0) ? 2'h2 : 2'h1);
            wr(4'h4, 2'h1);
            chk(terminal_connect_register_wr_mask_q, {{4{~l1}}, {4{~l0}}});
        end
        $display("test locks done");
        eeprom_busy <= 1'h1;
        tick(2);
        // eeprom_busy is held high here so the nonvolatile wiper writes are refused
        for (int a = 0; a < 6; a++)
            wr(a[3:0], a == 5 ? 2'h0
                : (a inside {2, 3}) ? 2'h2 : 2'h1);
        rd();
        eeprom_busy <= 1'h0;
        $display("test busy done");
        shutdown_pin_flag_n <= 1'h0;
        tick(5);
        rd();
        xfer(16'h00ff, 5'ha);
        wr(4'h0, 2'h1);
        // a read of any address but the status answers all zeros
        expq.push_back(16'h8000);
        xfer({4'h4, 2'h3, 10'h0}, 5'h10);
        shutdown_pin_flag_n <= 1'h1;
        tick(5);
        chk(16'(expq.size()), 16'h0);
        $display("test shutdown done");
        summarize();
    end
endmodule : psr_top_tb
`default_nettype wire
